// ==== src/bams_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - each phase watches only its own faults; others are ignored there.
// - power dropouts under 50 ms are ridden through; longer ones restart, except in lockout, which holds.
// - half-voltage sags are ridden through; past 100 ms they are only reported on SAG_LONG.
// - after power-up, start requests are ignored for about eight seconds.
// - start with load-series interlock open is refused with its error code.
// - load-series interlock opening in combustion drops the fuel valves.
// - false flame or self-discharge lasting five seconds in check locks out.
// - no flame at end of ignition trial locks out with alarm.
// - idle interlock opening is harmless; start with it open locks out.
module bams_top
   import bams_pkg::*;
#(
   parameter logic [31:0] N_HOLDOFF = N_HOLDOFF_CYC,
   parameter logic [31:0] N_FALSE   = N_FALSE_CYC,
   parameter logic [31:0] N_PWR     = N_PWR_CYC,
   parameter logic [31:0] N_SAG     = N_SAG_CYC,
   parameter logic [31:0] N_CHECK   = N_CHECK_CYC,
   parameter logic [31:0] N_IGN     = N_IGN_CYC,
   parameter logic [31:0] N_PILOT   = N_PILOT_CYC,
   parameter logic [31:0] N_MAIN    = N_MAIN_CYC
)(
   // clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        ARST_N,
   // contact and detector inputs
   input  wire logic        INTERLOCK,
   input  wire logic        START_REQ,
   input  wire logic        LOAD_ILK,
   input  wire logic        FLAME,
   input  wire logic        UV_ALARM,
   input  wire logic        PWR_OK,
   input  wire logic        SAG,
   input  wire logic        RESET_REQ,
   // loads
   output logic             IGN_ON,
   output logic             PILOT_ON,
   output logic             MAIN_ON,
   output logic             ALARM,
   // status
   output logic [3:0]       PHASE,
   output logic [11:0]      ERR_CODE,
   output logic             READY,
   output logic             SAG_LONG
);
   logic [IN_W-1:0] in_s;
   logic            ilk, start, load_ok, flame, uv, pwr_ok, sag, rst_req;
   bams_state_t     state_ff, nxt_state;
   logic [11:0]     err_ff, nxt_err;
   logic [31:0]     holdoff_ff, tmr_ff, false_ff, pwr_ff, sag_ff;
   logic            holdoff_done, pwr_long, sag_long;

   bams_sync bams_sync_inst (
      .clk    (CLK_SYS),
      .arst_n (ARST_N),
      .din    ({RESET_REQ, SAG, PWR_OK, UV_ALARM, FLAME, LOAD_ILK,
                START_REQ, INTERLOCK}),
      .dout   (in_s)
   );

   assign ilk     = in_s[IN_ILK];
   assign start   = in_s[IN_STRT];
   assign load_ok = in_s[IN_LOAD];
   assign flame   = in_s[IN_FLM];
   assign uv      = in_s[IN_UV];
   assign pwr_ok  = in_s[IN_PWR];
   assign sag     = in_s[IN_SAG];
   assign rst_req = in_s[IN_RST];

   assign holdoff_done = (holdoff_ff >= N_HOLDOFF);
   assign pwr_long     = (pwr_ff >= N_PWR);
   assign sag_long     = (sag_ff >= N_SAG);

   // power-on hold-off
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         holdoff_ff <= CNT_ZERO;
      end else if (!holdoff_done) begin
         holdoff_ff <= holdoff_ff + CNT_ONE;
      end
   end

   // dropout and sag duration, saturating
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         pwr_ff <= CNT_ZERO;
      end else if (pwr_ok) begin
         pwr_ff <= CNT_ZERO;
      end else if (!pwr_long) begin
         pwr_ff <= pwr_ff + CNT_ONE;
      end
   end

   // a long sag is only reported; flame loss shows up on the detector
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         sag_ff <= CNT_ZERO;
      end else if (!sag) begin
         sag_ff <= CNT_ZERO;
      end else if (!sag_long) begin
         sag_ff <= sag_ff + CNT_ONE;
      end
   end

   // time spent in the current phase
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         tmr_ff <= CNT_ZERO;
      end else if (nxt_state != state_ff) begin
         tmr_ff <= CNT_ZERO;
      end else if (tmr_ff != ~CNT_ZERO) begin
         tmr_ff <= tmr_ff + CNT_ONE;
      end
   end

   // persistence of flame or self-discharge during start check
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         false_ff <= CNT_ZERO;
      end else if (state_ff == ST_CHECK && (flame || uv)) begin
         if (false_ff < N_FALSE) begin
            false_ff <= false_ff + CNT_ONE;
         end
      end else begin
         false_ff <= CNT_ZERO;
      end
   end

   // sequence
   always_comb begin
      nxt_state = state_ff;
      nxt_err   = err_ff;
      case (state_ff)
         ST_STANDBY: begin
            if (holdoff_done && start) begin
               if (!ilk) begin
                  nxt_state = ST_LOCKOUT;
                  nxt_err   = ERR_INTERLOCK;
               end else if (!load_ok) begin
                  nxt_err   = LOAD_INTERLOCK_OPEN_ERROR;
               end else begin
                  nxt_state = ST_CHECK;
                  nxt_err   = ERR_NONE;
               end
            end else if (!start) begin
               nxt_err = ERR_NONE;
            end
         end
         ST_CHECK: begin
            if (!ilk) begin
               nxt_state = ST_LOCKOUT;
               nxt_err   = ERR_INTERLOCK;
            end else if (false_ff >= N_FALSE) begin
               nxt_state = ST_LOCKOUT;
               nxt_err   = flame ? ERR_FALSE_FLM : ERR_UV_ALARM;
            end else if (!start) begin
               nxt_state = ST_STANDBY;
            end else if (tmr_ff >= N_CHECK && !flame && !uv) begin
               nxt_state = ST_IGN;
            end
         end
         ST_IGN, ST_PILOT, ST_MAIN, ST_RUN: begin
            if (!ilk) begin
               nxt_state = ST_LOCKOUT;
               nxt_err   = ERR_INTERLOCK;
            end else if (uv) begin
               nxt_state = ST_LOCKOUT;
               nxt_err   = ERR_UV_ALARM;
            end else if (state_ff != ST_IGN && !flame) begin
               nxt_state = ST_LOCKOUT;
               nxt_err   = ERR_FLAME_FAIL;
            end else if (!load_ok) begin
               nxt_state = ST_STANDBY;
               nxt_err   = LOAD_INTERLOCK_OPEN_ERROR;
            end else if (!start) begin
               nxt_state = ST_STANDBY;
            end else if (state_ff == ST_IGN && tmr_ff >= N_IGN) begin
               // ignition failure is judged only here
               nxt_state = flame ? ST_PILOT : ST_LOCKOUT;
               nxt_err   = flame ? err_ff : ERR_IGN_FAIL;
            end else if (state_ff == ST_PILOT && tmr_ff >= N_PILOT) begin
               nxt_state = ST_MAIN;
            end else if (state_ff == ST_MAIN && tmr_ff >= N_MAIN) begin
               nxt_state = ST_RUN;
            end
         end
         ST_LOCKOUT: begin
            if (rst_req) begin
               nxt_state = ST_STANDBY;
               nxt_err   = ERR_NONE;
            end
         end
         default: begin
            nxt_state = ST_STANDBY;
         end
      endcase
      // lockout must survive a dropout, so it is exempt from the restart
      if (pwr_long && state_ff != ST_LOCKOUT) begin
         nxt_state = ST_STANDBY;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         state_ff <= ST_STANDBY;
         err_ff   <= ERR_NONE;
      end else begin
         state_ff <= nxt_state;
         err_ff   <= nxt_err;
      end
   end

   // outputs follow the next state so they line up with state_ff
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         IGN_ON   <= 1'b0;
         PILOT_ON <= 1'b0;
         MAIN_ON  <= 1'b0;
         ALARM    <= 1'b0;
      end else begin
         IGN_ON   <= (nxt_state == ST_IGN);
         PILOT_ON <= load_ok && (nxt_state == ST_IGN ||
                     nxt_state == ST_PILOT || nxt_state == ST_MAIN);
         MAIN_ON  <= load_ok && (nxt_state == ST_MAIN ||
                     nxt_state == ST_RUN);
         ALARM    <= (nxt_state == ST_LOCKOUT);
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         PHASE    <= STANDBY_PHASE_CODE;
         ERR_CODE <= ERR_NONE;
         READY    <= 1'b0;
         SAG_LONG <= 1'b0;
      end else begin
         case (nxt_state)
            ST_CHECK:   PHASE <= CHECK_PHASE_CODE;
            ST_IGN:     PHASE <= IGN_PHASE_CODE;
            ST_PILOT:   PHASE <= PILOT_ONLY_PHASE_CODE;
            ST_MAIN:    PHASE <= MAIN_TRIAL_PHASE_CODE;
            ST_RUN:     PHASE <= RUN_PHASE_CODE;
            ST_LOCKOUT: PHASE <= LOCKOUT_PHASE_CODE;
            default:    PHASE <= STANDBY_PHASE_CODE;
         endcase
         ERR_CODE <= nxt_err;
         READY    <= holdoff_done;
         SAG_LONG <= sag_long;
      end
   end

   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   property p_lock_outputs;
      state_ff == ST_LOCKOUT |-> ALARM && !IGN_ON && !PILOT_ON && !MAIN_ON;
   endproperty
   a_lock_outputs: assert property (p_lock_outputs)
      else $error("lockout outputs wrong");

   property p_lock_hold;
      state_ff == ST_LOCKOUT && !rst_req |=> state_ff == ST_LOCKOUT;
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("lockout left without reset");

   property p_holdoff;
      state_ff == ST_STANDBY && !holdoff_done |=> state_ff == ST_STANDBY;
   endproperty
   a_holdoff: assert property (p_holdoff)
      else $error("start taken during hold-off");

   property p_idle_ilk;
      state_ff == ST_STANDBY && !start |=> state_ff == ST_STANDBY;
   endproperty
   a_idle_ilk: assert property (p_idle_ilk)
      else $error("idle left without start");

   property p_start_ilk;
      state_ff == ST_STANDBY && holdoff_done && start && !ilk && !pwr_long
      |=> state_ff == ST_LOCKOUT && err_ff == ERR_INTERLOCK ##0 ALARM;
   endproperty
   a_start_ilk: assert property (p_start_ilk)
      else $error("start with interlock open not locked out");

   property p_load_refuse;
      state_ff == ST_STANDBY && holdoff_done && start && ilk && !load_ok
      && !pwr_long
      |=> state_ff == ST_STANDBY && ERR_CODE == LOAD_INTERLOCK_OPEN_ERROR;
   endproperty
   a_load_refuse: assert property (p_load_refuse)
      else $error("open load interlock not refused");

   property p_load_valves;
      !load_ok |=> !PILOT_ON && !MAIN_ON;
   endproperty
   a_load_valves: assert property (p_load_valves)
      else $error("valves on with load interlock open");

   property p_false_flame;
      state_ff == ST_CHECK && ilk && false_ff >= N_FALSE && !pwr_long
      |=> state_ff == ST_LOCKOUT;
   endproperty
   a_false_flame: assert property (p_false_flame)
      else $error("persistent false flame not locked out");

   property p_ign_fail;
      state_ff == ST_IGN && tmr_ff >= N_IGN && !flame && ilk && !uv
      && load_ok && start && !pwr_long
      |=> state_ff == ST_LOCKOUT && err_ff == ERR_IGN_FAIL;
   endproperty
   a_ign_fail: assert property (p_ign_fail)
      else $error("ignition failure missed");

   property p_flame_fail;
      state_ff == ST_RUN && !flame && ilk && !uv && !pwr_long
      |=> state_ff == ST_LOCKOUT && err_ff == ERR_FLAME_FAIL;
   endproperty
   a_flame_fail: assert property (p_flame_fail)
      else $error("flame failure in run missed");

   // flame inside the trial is expected, never a false-flame fault
   property p_no_false_late;
      state_ff == ST_IGN && flame && ilk && !uv && load_ok && start
      && !pwr_long && tmr_ff < N_IGN |=> state_ff == ST_IGN;
   endproperty
   a_no_false_late: assert property (p_no_false_late)
      else $error("flame in ignition trial treated as a fault");

   property p_pwr;
      pwr_long |=> state_ff == ST_STANDBY || state_ff == ST_LOCKOUT;
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("long dropout did not restart");

   property p_sag;
      sag && !$past(sag) && state_ff == ST_RUN && flame && ilk && !uv
      && load_ok && start && !pwr_long |=> state_ff == ST_RUN;
   endproperty
   a_sag: assert property (p_sag)
      else $error("sag interrupted run");

   c_run:     cover property (state_ff == ST_MAIN ##1 state_ff == ST_RUN);
   c_lockout: cover property (state_ff == ST_IGN ##1 state_ff == ST_LOCKOUT);
   c_refuse:  cover property (err_ff == LOAD_INTERLOCK_OPEN_ERROR);
   c_restart: cover property (pwr_long && state_ff == ST_RUN);
endmodule

// ==== src/bams_pkg.sv ====
package bams_pkg;
   // timebase
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   // times in ms
   localparam int unsigned T_HOLDOFF_MS  = 8000;
   localparam int unsigned T_FALSE_MS    = 5000;
   localparam int unsigned T_PWR_INT_MS  = 50;
   localparam int unsigned T_SAG_MS      = 100;
   localparam int unsigned T_CHECK_MS    = 2000;
   localparam int unsigned T_IGN_MS      = 5000;
   localparam int unsigned T_PILOT_MS    = 3000;
   localparam int unsigned T_MAIN_MS     = 5000;
   // derived counts in cycles
   localparam logic [31:0] N_HOLDOFF_CYC = 32'(T_HOLDOFF_MS * CYC_PER_MS);
   localparam logic [31:0] N_FALSE_CYC   = 32'(T_FALSE_MS * CYC_PER_MS);
   localparam logic [31:0] N_PWR_CYC     = 32'(T_PWR_INT_MS * CYC_PER_MS);
   localparam logic [31:0] N_SAG_CYC     = 32'(T_SAG_MS * CYC_PER_MS);
   localparam logic [31:0] N_CHECK_CYC   = 32'(T_CHECK_MS * CYC_PER_MS);
   localparam logic [31:0] N_IGN_CYC     = 32'(T_IGN_MS * CYC_PER_MS);
   localparam logic [31:0] N_PILOT_CYC   = 32'(T_PILOT_MS * CYC_PER_MS);
   localparam logic [31:0] N_MAIN_CYC    = 32'(T_MAIN_MS * CYC_PER_MS);
   localparam logic [31:0] CNT_ZERO      = 32'h0;
   localparam logic [31:0] CNT_ONE       = 32'h1;
   // synchronised input bit positions
   localparam int IN_W    = 8;
   localparam int IN_ILK  = 0;
   localparam int IN_STRT = 1;
   localparam int IN_LOAD = 2;
   localparam int IN_FLM  = 3;
   localparam int IN_UV   = 4;
   localparam int IN_PWR  = 5;
   localparam int IN_SAG  = 6;
   localparam int IN_RST  = 7;
   localparam logic [IN_W-1:0] IN_RST_VAL = 8'h00;
   // phase display codes
   localparam logic [3:0] STANDBY_PHASE_CODE    = 4'h0;
   localparam logic [3:0] CHECK_PHASE_CODE      = 4'h1;
   localparam logic [3:0] IGN_PHASE_CODE        = 4'h4;
   localparam logic [3:0] PILOT_ONLY_PHASE_CODE = 4'h5;
   localparam logic [3:0] MAIN_TRIAL_PHASE_CODE = 4'h6;
   localparam logic [3:0] RUN_PHASE_CODE        = 4'h8;
   localparam logic [3:0] LOCKOUT_PHASE_CODE    = 4'hf;
   // error codes
   localparam logic [11:0] ERR_NONE       = 12'hfff;
   localparam logic [11:0] ERR_INTERLOCK  = 12'h000;
   localparam logic [11:0] ERR_FALSE_FLM  = 12'h001;
   localparam logic [11:0] ERR_UV_ALARM   = 12'h003;
   localparam logic [11:0] ERR_IGN_FAIL   = 12'h006;
   localparam logic [11:0] ERR_FLAME_FAIL = 12'h007;
   localparam logic [11:0] LOAD_INTERLOCK_OPEN_ERROR = 12'h966;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_CHECK,
      ST_IGN,
      ST_PILOT,
      ST_MAIN,
      ST_RUN,
      ST_LOCKOUT
   } bams_state_t;
endpackage

// ==== src/bams_sync.sv ====
`timescale 1ns/1ps
module bams_sync
   import bams_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            arst_n,
   // levels
   input  wire logic [IN_W-1:0] din,
   output logic      [IN_W-1:0] dout
);
   logic [IN_W-1:0] meta_ff;
   logic [IN_W-1:0] sync_ff;

   genvar i;
   generate
      for (i = 0; i < IN_W; i++) begin : g_bit
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_ff[i] <= IN_RST_VAL[i];
               sync_ff[i] <= IN_RST_VAL[i];
            end else begin
               meta_ff[i] <= din[i];
               sync_ff[i] <= meta_ff[i];
            end
         end
      end
   endgenerate

   assign dout = sync_ff;
endmodule

// ==== testbench/bams_plant.sv ====
`timescale 1ns/1ps
module bams_plant (
   // clock
   input  wire logic clk,
   // fuel valves from the sequencer
   input  wire logic pilot_on,
   input  wire logic main_on,
   // scenario controls
   input  wire logic lit_en,
   input  wire logic stray,
   input  wire logic uv_fault,
   // detector outputs
   output logic      flame,
   output logic      uv_alarm
);
   logic [2:0] burn_ff;

   // flame needs a few cycles of fuel; it dies one cycle after fuel stops
   always_ff @(posedge clk) begin
      if (!(pilot_on || main_on) || !lit_en) begin
         burn_ff <= 3'h0;
      end else if (burn_ff != 3'h3) begin
         burn_ff <= burn_ff + 3'h1;
      end
   end

   // stray light shows as flame whatever the valves do
   assign flame    = stray || (burn_ff == 3'h3);
   assign uv_alarm = uv_fault;
endmodule

// ==== testbench/bams_top_tb.sv ====
`timescale 1ns/1ps
module bams_top_tb;
   import bams_pkg::*;
   // shortened counts keep the run under two thousand cycles
   localparam logic [31:0] NH  = 32'h3c;
   localparam logic [31:0] NF  = 32'h28;
   localparam logic [31:0] NP  = 32'h14;
   localparam logic [31:0] NS  = 32'h1e;
   localparam logic [31:0] NC  = 32'h14;
   localparam logic [31:0] NI  = 32'h28;
   localparam logic [31:0] NPL = 32'h1e;
   localparam logic [31:0] NM  = 32'h1e;

   logic        clk_sys;
   logic        arst_n;
   logic        ilk;
   logic        strt;
   logic        load;
   logic        pwr;
   logic        sag;
   logic        rst_req;
   logic        lit;
   logic        stray;
   logic        uvf;
   logic        flame;
   logic        uv;
   logic        ign_on;
   logic        pilot_on;
   logic        main_on;
   logic        alarm;
   logic        ready;
   logic        sag_long;
   logic [3:0]  phase;
   logic [11:0] err;
   int          miscompares;
   int          tests_run;

   bams_top #(.N_HOLDOFF(NH), .N_FALSE(NF), .N_PWR(NP), .N_SAG(NS),
      .N_CHECK(NC), .N_IGN(NI), .N_PILOT(NPL), .N_MAIN(NM)) bams_top_inst (
      .CLK_SYS(clk_sys), .ARST_N(arst_n), .INTERLOCK(ilk),
      .START_REQ(strt), .LOAD_ILK(load), .FLAME(flame), .UV_ALARM(uv),
      .PWR_OK(pwr), .SAG(sag), .RESET_REQ(rst_req), .IGN_ON(ign_on),
      .PILOT_ON(pilot_on), .MAIN_ON(main_on), .ALARM(alarm),
      .PHASE(phase), .ERR_CODE(err), .READY(ready), .SAG_LONG(sag_long));

   bams_plant bams_plant_inst (
      .clk(clk_sys), .pilot_on(pilot_on), .main_on(main_on),
      .lit_en(lit), .stray(stray), .uv_fault(uvf), .flame(flame),
      .uv_alarm(uv));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // bounded wait for a phase code, then judge it
   task automatic wait_ph(input logic [3:0] exp, input int lim);
      int n;
      n = 0;
      while (phase !== exp && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      chk(12'(phase), 12'(exp));
   endtask

   task automatic chk_loads(input logic [2:0] exp);
      chk(12'({ign_on, pilot_on, main_on}), 12'(exp));
   endtask

   task automatic go_run;
      strt = 1'b1;
      wait_ph(CHECK_PHASE_CODE, 8);
      chk_loads(3'h0);
      wait_ph(IGN_PHASE_CODE, int'(NC) + 8);
      chk_loads(3'h6);
      wait_ph(PILOT_ONLY_PHASE_CODE, int'(NI) + 8);
      chk_loads(3'h2);
      wait_ph(MAIN_TRIAL_PHASE_CODE, int'(NPL) + 8);
      chk_loads(3'h3);
      wait_ph(RUN_PHASE_CODE, int'(NM) + 8);
      chk_loads(3'h1);
   endtask

   // lockout must hold with start gone, until reset is asked for
   task automatic clr_lock(input logic [11:0] exp_err);
      chk(err, exp_err);
      strt = 1'b0;
      cyc(10);
      chk(12'(phase), 12'(LOCKOUT_PHASE_CODE));
      chk(12'({alarm, ign_on, pilot_on, main_on}), 12'h8);
      rst_req = 1'b1;
      wait_ph(STANDBY_PHASE_CODE, 8);
      chk(12'(alarm), 12'h0);
      rst_req = 1'b0;
      cyc(4);
   endtask

   task automatic t_holdoff;
      strt = 1'b1;
      cyc(int'(NH) / 2);
      chk(12'({ready, phase}), 12'h0);
      wait_ph(CHECK_PHASE_CODE, int'(NH) + 10);
      chk(12'(ready), 12'h1);
      strt = 1'b0;
      wait_ph(STANDBY_PHASE_CODE, 8);
   endtask

   task automatic t_ride;
      go_run;
      pwr = 1'b0;
      cyc(int'(NP) / 2);
      pwr = 1'b1;
      cyc(6);
      chk(12'(phase), 12'(RUN_PHASE_CODE));
      chk_loads(3'h1);
      sag = 1'b1;
      cyc(int'(NS) / 2);
      chk(12'({sag_long, phase}), 12'(RUN_PHASE_CODE));
      cyc(int'(NS));
      chk(12'({sag_long, phase}), 12'h18);
      sag = 1'b0;
      cyc(6);
      chk(12'(sag_long), 12'h0);
      // long dropout restarts from standby and drops the loads
      pwr = 1'b0;
      wait_ph(STANDBY_PHASE_CODE, int'(NP) + 8);
      chk_loads(3'h0);
      strt = 1'b0;
      pwr = 1'b1;
      cyc(6);
      chk(12'(phase), 12'(STANDBY_PHASE_CODE));
   endtask

   task automatic t_load;
      load = 1'b0;
      strt = 1'b1;
      cyc(8);
      chk(12'(phase), 12'(STANDBY_PHASE_CODE));
      chk(err, LOAD_INTERLOCK_OPEN_ERROR);
      strt = 1'b0;
      load = 1'b1;
      cyc(6);
      go_run;
      load = 1'b0;
      cyc(4);
      chk_loads(3'h0);
      chk(err, LOAD_INTERLOCK_OPEN_ERROR);
      strt = 1'b0;
      load = 1'b1;
      cyc(6);
   endtask

   task automatic t_false;
      stray = 1'b1;
      strt = 1'b1;
      wait_ph(CHECK_PHASE_CODE, 8);
      cyc(int'(NF) - 8);
      chk(12'(phase), 12'(CHECK_PHASE_CODE));
      chk_loads(3'h0);
      wait_ph(LOCKOUT_PHASE_CODE, 16);
      stray = 1'b0;
      clr_lock(ERR_FALSE_FLM);
   endtask

   task automatic t_ignfail;
      lit = 1'b0;
      strt = 1'b1;
      wait_ph(IGN_PHASE_CODE, int'(NC) + 12);
      cyc(int'(NI) - 8);
      chk(12'(phase), 12'(IGN_PHASE_CODE));
      wait_ph(LOCKOUT_PHASE_CODE, 16);
      lit = 1'b1;
      clr_lock(ERR_IGN_FAIL);
   endtask

   task automatic t_runfaults;
      go_run;
      uvf = 1'b1;
      wait_ph(LOCKOUT_PHASE_CODE, 8);
      uvf = 1'b0;
      clr_lock(ERR_UV_ALARM);
      go_run;
      lit = 1'b0;
      wait_ph(LOCKOUT_PHASE_CODE, 12);
      lit = 1'b1;
      clr_lock(ERR_FLAME_FAIL);
   endtask

   task automatic t_ilk;
      ilk = 1'b0;
      cyc(12);
      chk(12'({alarm, phase}), 12'(STANDBY_PHASE_CODE));
      strt = 1'b1;
      wait_ph(LOCKOUT_PHASE_CODE, 8);
      ilk = 1'b1;
      clr_lock(ERR_INTERLOCK);
   endtask

   initial begin
      miscompares = 0;
      tests_run = 0;
      arst_n = 1'b0;
      ilk = 1'b1;
      strt = 1'b0;
      load = 1'b1;
      pwr = 1'b1;
      sag = 1'b0;
      rst_req = 1'b0;
      lit = 1'b1;
      stray = 1'b0;
      uvf = 1'b0;
      cyc(5);
      arst_n = 1'b1;
      t_holdoff;
      t_ride;
      t_load;
      t_false;
      t_ignfail;
      t_runfaults;
      t_ilk;
      give_verdict;
   end

   // the tests need under two thousand cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      miscompares++;
      give_verdict;
   end
endmodule
